/* File: ssd_ctrl.sv */
// slow-stop controller: registers, stop sequencing, decel ramp
// assumes triggers and velocity feedback synchronous to mclk_i
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ns
module ssd_ctrl #(
    parameter int TICK_CYCLES = ssd_pkg::CTRL_CYCLES,
    parameter logic [15:0] ZERO_VEL = 16'h000A
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire ssd_pkg::ssd_trig_t trig_i,
    input wire logic servo_on_i,
    input wire logic signed [15:0] act_vel_i,
    output logic signed [15:0] vel_cmd_o,
    output logic slow_active_o,
    output logic force_pos_o,
    output logic alarm_o,
    output logic irq_o
);
    // =========================================
    // register file
    logic [15:0] mains_seq_q, mains_seq_d, alarm_seq_q, alarm_seq_d;
    logic [15:0] slope_q, slope_d, scurve_q, scurve_d;
    logic [15:0] fext_q, fext_d, tlimit_q, tlimit_d, rdata_d;
    logic [ssd_pkg::IRQ_W-1:0] irq_st_q, irq_st_d, irq_en_q, irq_en_d;
    logic [ssd_pkg::IRQ_W-1:0] ev;
    logic irq_d;
    ssd_pkg::ssd_state_t st_q, st_d;

    always_comb begin
        mains_seq_d = mains_seq_q;
        alarm_seq_d = alarm_seq_q;
        slope_d = slope_q;
        scurve_d = scurve_q;
        fext_d = fext_q;
        tlimit_d = tlimit_q;
        irq_en_d = irq_en_q;
        irq_st_d = irq_st_q;
        rdata_d = ssd_pkg::RST_ZERO;
        if (wr_i) begin
            case (addr_i)
                ssd_pkg::REG_MAINS_SEQ: mains_seq_d = wdata_i;
                ssd_pkg::REG_ALARM_SEQ: alarm_seq_d = wdata_i;
                ssd_pkg::REG_SLOPE: slope_d = wdata_i;
                ssd_pkg::REG_SCURVE: scurve_d = wdata_i;
                ssd_pkg::REG_FUNC_EXT: fext_d = wdata_i;
                ssd_pkg::REG_TLIMIT: tlimit_d = wdata_i;
                ssd_pkg::REG_IRQ_EN: irq_en_d = wdata_i[ssd_pkg::IRQ_W-1:0];
                ssd_pkg::REG_IRQ_CLR: irq_st_d = irq_st_q & ~wdata_i[ssd_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        // a new event beats a clear in the same cycle
        irq_st_d = irq_st_d | ev;
        if (rd_i) begin
            case (addr_i)
                ssd_pkg::REG_MAINS_SEQ: rdata_d = mains_seq_q;
                ssd_pkg::REG_ALARM_SEQ: rdata_d = alarm_seq_q;
                ssd_pkg::REG_SLOPE: rdata_d = slope_q;
                ssd_pkg::REG_SCURVE: rdata_d = scurve_q;
                ssd_pkg::REG_FUNC_EXT: rdata_d = fext_q;
                ssd_pkg::REG_TLIMIT: rdata_d = tlimit_q;
                ssd_pkg::REG_STATE: rdata_d = 16'(st_q);
                ssd_pkg::REG_IRQ_STAT: rdata_d = 16'(irq_st_q);
                ssd_pkg::REG_IRQ_EN: rdata_d = 16'(irq_en_q);
                default: rdata_d = ssd_pkg::RST_ZERO;
            endcase
        end
        irq_d = |(irq_st_d & irq_en_d);
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mains_seq_q <= ssd_pkg::RST_ZERO;
            alarm_seq_q <= ssd_pkg::RST_ZERO;
            slope_q <= ssd_pkg::RST_ZERO;
            scurve_q <= ssd_pkg::RST_ZERO;
            fext_q <= ssd_pkg::RST_ZERO;
            tlimit_q <= ssd_pkg::RST_ZERO;
            irq_st_q <= '0;
            irq_en_q <= '0;
            rdata_o <= ssd_pkg::RST_ZERO;
            irq_o <= 1'b0;
        end else begin
            mains_seq_q <= mains_seq_d;
            alarm_seq_q <= alarm_seq_d;
            slope_q <= slope_d;
            scurve_q <= scurve_d;
            fext_q <= fext_d;
            tlimit_q <= tlimit_d;
            irq_st_q <= irq_st_d;
            irq_en_q <= irq_en_d;
            rdata_o <= rdata_d;
            irq_o <= irq_d;
        end
    end

    // =========================================
    // control-cycle tick and s-curve divider
    logic tick;
    logic div_start, div_done;
    logic [ssd_pkg::DIV_W-1:0] div_num, div_quo;

    // tick period must exceed the divider latency, or every division restarts
    ssd_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .tick_o(tick)
    );

    ssd_div #(.W(ssd_pkg::DIV_W)) u_div (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .start_i(div_start),
        .num_i(div_num),
        .den_i(ssd_pkg::DIV_W'(scurve_q)),
        .done_o(div_done),
        .quo_o(div_quo)
    );

    // =========================================
    // stop sequencing and ramp
    logic en, any_stop, alm_tmo, at_rest, s_phase;
    logic [15:0] act_abs;
    logic [15:0] mag_q, mag_d, ms_q, ms_d, t_q, t_d;
    logic [31:0] acc_q, acc_d;
    logic neg_q, neg_d, cause_alm_q, cause_alm_d;
    logic signed [15:0] vel_d;

    always_comb begin
        en = fext_q[ssd_pkg::FE_SLOW_EN_BIT]; // R3
        act_abs = act_vel_i[15] ? 16'(-act_vel_i) : act_vel_i;
        at_rest = (act_abs <= ZERO_VEL); // R10
        any_stop = trig_i.prohibit | trig_i.servo_off | trig_i.mains_off | trig_i.alarm_es; // R13
        alm_tmo = cause_alm_q && (ms_q >= tlimit_q); // R6
        s_phase = (scurve_q != ssd_pkg::RST_ZERO) && (t_q < scurve_q); // R15
        div_start = (st_q == ssd_pkg::ST_RAMP) && tick && s_phase;
        div_num = ssd_pkg::DIV_W'(t_q) * ssd_pkg::DIV_W'(ssd_pkg::RPM_STEP);
        st_d = st_q;
        mag_d = mag_q;
        acc_d = acc_q;
        neg_d = neg_q;
        t_d = t_q;
        ms_d = ms_q;
        cause_alm_d = cause_alm_q;
        ev = '0;
        case (st_q)
            ssd_pkg::ST_IDLE: begin
                if (trig_i.alarm_nes || (trig_i.alarm_es && (!en || !servo_on_i))) begin
                    st_d = ssd_pkg::ST_ALARM;
                end else if (trig_i.alarm_es && tlimit_q == ssd_pkg::RST_ZERO) begin
                    st_d = ssd_pkg::ST_ALARM; // R7
                end else if (en && servo_on_i && any_stop) begin // R18
                    st_d = ssd_pkg::ST_RAMP; // R12
                    mag_d = act_abs; // R11
                    neg_d = act_vel_i[15];
                    acc_d = '0;
                    t_d = ssd_pkg::RST_ZERO;
                    ms_d = ssd_pkg::RST_ZERO;
                    cause_alm_d = trig_i.alarm_es;
                    ev[ssd_pkg::IRQ_START] = 1'b1;
                end
            end
            ssd_pkg::ST_RAMP: begin
                if (trig_i.alarm_es) begin
                    cause_alm_d = 1'b1; // R8
                end
                if (trig_i.alarm_nes || alm_tmo) begin
                    st_d = ssd_pkg::ST_ALARM; // R9
                    ev[ssd_pkg::IRQ_TMO] = alm_tmo;
                end else if (!servo_on_i) begin
                    st_d = ssd_pkg::ST_IDLE;
                end else if (at_rest) begin
                    st_d = ssd_pkg::ST_DONE;
                    mag_d = ssd_pkg::RST_ZERO;
                    ev[ssd_pkg::IRQ_DONE] = 1'b1;
                end else begin
                    if (tick) begin
                        t_d = (t_q == 16'hFFFF) ? t_q : t_q + 16'h0001;
                        if (cause_alm_q) begin
                            ms_d = (ms_q == 16'hFFFF) ? ms_q : ms_q + 16'h0001;
                        end
                        if (!s_phase) begin
                            acc_d = acc_q + 32'(ssd_pkg::RPM_STEP); // R14
                        end
                    end else if (div_done) begin
                        acc_d = acc_q + 32'(div_quo); // R2
                    end else if (slope_q == ssd_pkg::RST_ZERO) begin
                        mag_d = ssd_pkg::RST_ZERO;
                    end else if (acc_q >= 32'(slope_q) && mag_q != ssd_pkg::RST_ZERO) begin
                        // spread the per-cycle drop over clocks to avoid a divider
                        acc_d = acc_q - 32'(slope_q); // R1
                        mag_d = mag_q - 16'h0001; // R19
                    end
                    if (mag_q == ssd_pkg::RST_ZERO) begin
                        acc_d = '0;
                    end
                end
            end
            ssd_pkg::ST_DONE: begin
                if (trig_i.alarm_nes || trig_i.alarm_es) begin
                    st_d = ssd_pkg::ST_ALARM;
                end else if (!any_stop) begin
                    st_d = ssd_pkg::ST_IDLE;
                end
            end
            ssd_pkg::ST_ALARM: begin
                if (!trig_i.alarm_es && !trig_i.alarm_nes) begin
                    st_d = ssd_pkg::ST_IDLE;
                end
            end
            default: st_d = ssd_pkg::ST_IDLE;
        endcase
        if (st_d == ssd_pkg::ST_ALARM && st_q != ssd_pkg::ST_ALARM) begin
            ev[ssd_pkg::IRQ_ALARM] = 1'b1;
            mag_d = ssd_pkg::RST_ZERO;
        end
        if (st_d == ssd_pkg::ST_IDLE) begin
            mag_d = ssd_pkg::RST_ZERO;
        end
        vel_d = neg_d ? -$signed(mag_d) : $signed(mag_d);
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= ssd_pkg::ST_IDLE;
            mag_q <= ssd_pkg::RST_ZERO;
            acc_q <= '0;
            neg_q <= 1'b0;
            t_q <= ssd_pkg::RST_ZERO;
            ms_q <= ssd_pkg::RST_ZERO;
            cause_alm_q <= 1'b0;
            vel_cmd_o <= '0;
            slow_active_o <= 1'b0;
            force_pos_o <= 1'b0;
            alarm_o <= 1'b0;
        end else begin
            st_q <= st_d;
            mag_q <= mag_d;
            acc_q <= acc_d;
            neg_q <= neg_d;
            t_q <= t_d;
            ms_q <= ms_d;
            cause_alm_q <= cause_alm_d;
            vel_cmd_o <= vel_d;
            slow_active_o <= (st_d == ssd_pkg::ST_RAMP);
            force_pos_o <= (st_d == ssd_pkg::ST_RAMP) || (st_d == ssd_pkg::ST_DONE); // R17
            alarm_o <= (st_d == ssd_pkg::ST_ALARM);
        end
    end

    // =========================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_start;
        st_q == ssd_pkg::ST_IDLE && en && servo_on_i && any_stop && !trig_i.alarm_nes
            && !(trig_i.alarm_es && tlimit_q == ssd_pkg::RST_ZERO);
    endsequence

    a_stop_start: assert property (s_start |=> st_q == ssd_pkg::ST_RAMP) // R13
        else $error("slow stop did not start");
    a_switch_time: assert property (s_start |=> slow_active_o && force_pos_o) // R12
        else $error("slow stop outputs late");
    a_init_actual: assert property (s_start |=> mag_q == $past(act_abs)) // R11
        else $error("ramp not seeded from actual velocity");
    a_nes_alarm: assert property (trig_i.alarm_nes |=> st_q == ssd_pkg::ST_ALARM) // R9
        else $error("non-stopping alarm not immediate");
    a_zero_limit: assert property (st_q == ssd_pkg::ST_IDLE && trig_i.alarm_es
        && tlimit_q == ssd_pkg::RST_ZERO |=> alarm_o) // R7
        else $error("zero limit did not alarm at once");
    a_time_limit: assert property (st_q == ssd_pkg::ST_RAMP && alm_tmo
        |=> st_q == ssd_pkg::ST_ALARM && alarm_o) // R6
        else $error("alarm stop overran its limit");
    a_limit_scope: assert property (st_q == ssd_pkg::ST_RAMP && !cause_alm_q
        && !trig_i.alarm_es && !trig_i.alarm_nes |=> st_q != ssd_pkg::ST_ALARM) // R8
        else $error("limit applied to non-alarm stop");
    a_no_overshoot: assert property (st_q == ssd_pkg::ST_RAMP
        ##1 st_q == ssd_pkg::ST_RAMP |-> mag_q <= $past(mag_q) && neg_q == $past(neg_q)) // R19
        else $error("command rose or reversed");
    a_actual_done: assert property (st_q == ssd_pkg::ST_RAMP && at_rest && servo_on_i
        && !trig_i.alarm_nes && !alm_tmo |=> st_q == ssd_pkg::ST_DONE) // R10
        else $error("stop not judged from actual velocity");
    a_disabled: assert property (st_q == ssd_pkg::ST_IDLE && !en
        |=> st_q != ssd_pkg::ST_RAMP) // R3
        else $error("slow stop ran while disabled");
    a_servo_on: assert property (!servo_on_i && st_q == ssd_pkg::ST_IDLE
        |=> !slow_active_o) // R18
        else $error("slow stop without servo on");

    localparam int DIV_LAT = ssd_pkg::DIV_W + 1;

    // one ordinary ramp cycle: no exit condition is present
    sequence s_ramp_hold;
        st_q == ssd_pkg::ST_RAMP && !at_rest && servo_on_i
            && !trig_i.alarm_nes && !alm_tmo;
    endsequence

    // ramp gain, slope step, timer, output and exit checks
    a_linear_gain: assert property (s_ramp_hold ##0 (tick && !s_phase // R14
        && mag_q != ssd_pkg::RST_ZERO) |=> acc_q == $past(acc_q) + 32'(ssd_pkg::RPM_STEP))
        else $error("linear gain missed");
    a_s_hold: assert property (s_ramp_hold ##0 (tick && s_phase // R15
        && mag_q != ssd_pkg::RST_ZERO) |=> acc_q == $past(acc_q))
        else $error("full gain inside s-curve");
    a_s_gain: assert property (s_ramp_hold ##0 (div_done && !tick // R2
        && mag_q != ssd_pkg::RST_ZERO) |=> acc_q == $past(acc_q) + 32'($past(div_quo)))
        else $error("s-curve gain missed");
    a_div_latency: assert property (div_start |-> ##DIV_LAT div_done) // R2
        else $error("division did not finish");
    a_slope_step: assert property (s_ramp_hold ##0 (!tick && !div_done // R1
        && slope_q != ssd_pkg::RST_ZERO && acc_q >= 32'(slope_q)
        && mag_q != ssd_pkg::RST_ZERO) |=> mag_q == $past(mag_q) - 16'h0001)
        else $error("slope step missed");
    a_slope_zero: assert property (s_ramp_hold ##0 (!tick && !div_done // R1
        && slope_q == ssd_pkg::RST_ZERO) |=> mag_q == ssd_pkg::RST_ZERO)
        else $error("zero slope did not stop");
    a_timer_step: assert property (s_ramp_hold ##0 (tick && cause_alm_q // R6
        && ms_q != 16'hFFFF) |=> ms_q == $past(ms_q) + 16'h0001)
        else $error("alarm stop timer stalled");
    a_timer_still: assert property (s_ramp_hold ##0 (!cause_alm_q) // R8
        |=> ms_q == $past(ms_q))
        else $error("timer ran for non-alarm stop");
    a_force_pos: assert property (st_q == ssd_pkg::ST_RAMP // R17
        || st_q == ssd_pkg::ST_DONE |-> force_pos_o)
        else $error("position control not forced");
    a_done_still: assert property (st_q == ssd_pkg::ST_DONE // R10
        |-> vel_cmd_o == '0)
        else $error("command not zero when done");
    a_alarm_still: assert property (alarm_o // R9
        |-> vel_cmd_o == '0)
        else $error("command not zero in alarm");
    a_seed_sign: assert property (s_start // R11
        |=> neg_q == $past(act_vel_i[15]))
        else $error("ramp direction not from actual");
    a_servo_drop: assert property (st_q == ssd_pkg::ST_RAMP && !servo_on_i // R18
        && !trig_i.alarm_nes && !alm_tmo |=> st_q == ssd_pkg::ST_IDLE && vel_cmd_o == '0)
        else $error("servo drop did not end ramp");
endmodule

/* File: ssd_div.sv */
// serial restoring divider, one quotient bit per clock
// assumes start only while not busy; divide by zero gives all ones
`timescale 1ns/1ns
module ssd_div #(
    parameter int W = 20
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [W-1:0] num_i,
    input wire logic [W-1:0] den_i,
    output logic done_o,
    output logic [W-1:0] quo_o
);
    logic [W-1:0] rem_q, rem_d, quo_d, den_q, den_d;
    logic [5:0] cnt_q, cnt_d;
    logic done_d;
    logic [W:0] trial;
    always_comb begin
        rem_d = rem_q;
        quo_d = quo_o;
        den_d = den_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        trial = {rem_q, quo_o[W-1]} - {1'b0, den_q};
        if (start_i) begin
            rem_d = '0;
            quo_d = num_i;
            den_d = den_i;
            cnt_d = 6'(W);
        end else if (cnt_q != 6'h00) begin
            if (!trial[W]) begin
                rem_d = trial[W-1:0];
                quo_d = {quo_o[W-2:0], 1'b1};
            end else begin
                rem_d = {rem_q[W-2:0], quo_o[W-1]};
                quo_d = {quo_o[W-2:0], 1'b0};
            end
            cnt_d = cnt_q - 6'h01;
            done_d = (cnt_q == 6'h01);
        end
    end
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rem_q <= '0;
            quo_o <= '0;
            den_q <= '0;
            cnt_q <= 6'h00;
            done_o <= 1'b0;
        end else begin
            rem_q <= rem_d;
            quo_o <= quo_d;
            den_q <= den_d;
            cnt_q <= cnt_d;
            done_o <= done_d;
        end
    end
endmodule

/* File: ssd_motor.sv */
// servo loop model: actual velocity feedback for the slow-stop block
// assumes the one system clock; drive follows the command only when forced
`timescale 1ns/1ns
module ssd_motor (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic signed [15:0] vel_cmd_i,
    input wire logic force_pos_i,
    input wire logic signed [15:0] run_vel_i,
    input wire logic lag_i,
    output logic signed [15:0] act_vel_o
);
    // =========================================
    // velocity loop
    // lag mode slews one r/min per clock, so feedback trails the command
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            act_vel_o <= 16'sh0000;
        end else if (!force_pos_i) begin
            act_vel_o <= run_vel_i;
        end else if (!lag_i) begin
            act_vel_o <= vel_cmd_i;
        end else if (act_vel_o > vel_cmd_i) begin
            act_vel_o <= act_vel_o - 16'sh0001;
        end else if (act_vel_o < vel_cmd_i) begin
            act_vel_o <= act_vel_o + 16'sh0001;
        end
    end
endmodule

/* File: ssd_pkg.sv */
// slow-stop deceleration controller: shared constants and types
// assumes one 25 MHz clock and a register port with 4-bit word index
// Operation
// (R1) slope register sets ms per 1000 r/min
// (R2) s-curve time rounds the deceleration start
// (R3) function word bit 15 enables slow stop
// (R4) software sets fall-prevention bit 10 too
// (R5) software selects stop sequences for mains, alarm
// (R6) alarm stop beyond time limit forces alarm
// (R7) zero time limit means alarm at once
// (R8) time limit applies to alarm stops only
// (R9) non-stopping alarm forces alarm state immediately
// (R10) completion judged from actual velocity
// (R11) ramp starts from measured actual velocity
// (R12) switch into slow stop within 5 ms
// (R13) prohibit, servo-off, mains-off, stop alarm start it
// (R14) zero s-time gives linear ramp
// (R15) nonzero s-time adds s-shaped rounding
// (R16) software keeps time limit above decel time
// (R17) force position control during the stop
// (R18) slow stop only while servo is on
// (R19) one update per control cycle, clamp zero; code steps 1 r/min per clock while acc_q >= slope_q
package ssd_pkg;
    // =========================================
    // register indices
    localparam logic [3:0] REG_MAINS_SEQ = 4'h0;
    localparam logic [3:0] REG_ALARM_SEQ = 4'h1;
    localparam logic [3:0] REG_SLOPE = 4'h2;
    localparam logic [3:0] REG_SCURVE = 4'h3;
    localparam logic [3:0] REG_FUNC_EXT = 4'h4;
    localparam logic [3:0] REG_TLIMIT = 4'h5;
    localparam logic [3:0] REG_STATE = 4'h6;
    localparam logic [3:0] REG_IRQ_STAT = 4'h7;
    localparam logic [3:0] REG_IRQ_EN = 4'h8;
    localparam logic [3:0] REG_IRQ_CLR = 4'h9;
    // =========================================
    // fields and reset values
    localparam int FE_SLOW_EN_BIT = 15;
    localparam int FE_FALL_BIT = 10;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RPM_STEP = 16'h03E8;
    localparam int IRQ_W = 4;
    localparam int IRQ_START = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_TMO = 2;
    localparam int IRQ_ALARM = 3;
    // =========================================
    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int CTRL_PERIOD_US = 1000;
    localparam int CTRL_CYCLES = CLK_HZ / 1_000_000 * CTRL_PERIOD_US;
    localparam int DIV_W = 20;
    // =========================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RAMP = 3'b001,
        ST_DONE = 3'b010,
        ST_ALARM = 3'b011
    } ssd_state_t;
    typedef struct packed {
        logic prohibit;
        logic servo_off;
        logic mains_off;
        logic alarm_es;
        logic alarm_nes;
    } ssd_trig_t;
endpackage

/* File: ssd_tick.sv */
// control-cycle enable divider
// assumes the one system clock; pulse is one cycle wide
`timescale 1ns/1ns
module ssd_tick #(
    parameter int CYCLES = 25000
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    output logic tick_o
);
    logic [31:0] cnt_q, cnt_d;
    logic tick_d;
    always_comb begin
        tick_d = (cnt_q == 32'(CYCLES - 1));
        cnt_d = tick_d ? 32'h0 : cnt_q + 32'h1;
    end
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= 32'h0;
            tick_o <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_o <= tick_d;
        end
    end
endmodule

/* File: tb.sv */
// self-checking bench for the slow-stop controller
// assumes ssd_pkg, ssd_ctrl and the servo loop model are compiled first
`timescale 1ns/1ns
module tb;
    localparam int TK = 24;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    ssd_pkg::ssd_trig_t trig_i = 5'h00;
    logic servo_on_i = 1'b0;
    logic signed [15:0] act_vel_i;
    logic signed [15:0] vel_cmd_o;
    logic slow_active_o, force_pos_o, alarm_o, irq_o;
    logic signed [15:0] run_vel = 16'sh0000;
    logic lag = 1'b0;
    logic [15:0] v;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int i, k, t_lin, t_s;

    ssd_ctrl #(.TICK_CYCLES(TK)) dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trig_i(trig_i),
        .servo_on_i(servo_on_i), .act_vel_i(act_vel_i), .vel_cmd_o(vel_cmd_o),
        .slow_active_o(slow_active_o), .force_pos_o(force_pos_o), .alarm_o(alarm_o),
        .irq_o(irq_o));
    ssd_motor motor_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .vel_cmd_i(vel_cmd_o),
        .force_pos_i(force_pos_o), .run_vel_i(run_vel), .lag_i(lag), .act_vel_o(act_vel_i));

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    // =========================================
    // reporting
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // run is a few thousand cycles; a hang cannot pass
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            complete_run();
        end
    end

    // =========================================
    // register port
    // one idle edge after each strobe so no strobe is set twice at one edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic cfg(input logic [15:0] sl, input logic [15:0] sc, input logic [15:0] lim);
        wr(ssd_pkg::REG_SLOPE, sl);
        wr(ssd_pkg::REG_SCURVE, sc);
        wr(ssd_pkg::REG_TLIMIT, lim);
    endtask

    // =========================================
    // stop sequencing
    task automatic arm(input logic [4:0] t, input logic [15:0] v0);
        @(posedge mclk_i);
        run_vel <= v0;
        repeat (3) @(posedge mclk_i);
        trig_i <= t;
        for (k = 0; k < 6 * TK && slow_active_o !== 1'b1; k++) @(negedge mclk_i);
        chk("start_time", k <= 5 * TK, 1'b1);
        chk("start_vel", vel_cmd_o, v0);
        chk("pos_forced", force_pos_o, 1'b1);
    endtask

    task automatic run_stop(input logic [4:0] t, input logic [15:0] v0, output int dt);
        logic neg;
        neg = 1'b0;
        arm(t, v0);
        for (dt = 0; dt < 4000 && slow_active_o === 1'b1; dt++) begin
            neg = neg | vel_cmd_o[15];
            @(negedge mclk_i);
        end
        chk("no_reverse", neg, 1'b0);
        chk("stop_vel", vel_cmd_o, 16'h0000);
        chk("done_pos", force_pos_o, 1'b1);
        chk("done_alarm", alarm_o, 1'b0);
        @(posedge mclk_i);
        trig_i <= 5'h00;
        repeat (3) @(negedge mclk_i);
        chk("idle_pos", force_pos_o, 1'b0);
    endtask

    task automatic hit(input logic [4:0] t, input string nm, input logic [15:0] exp);
        @(posedge mclk_i);
        trig_i <= t;
        repeat (2) @(negedge mclk_i);
        chk(nm, alarm_o, exp);
    endtask

    // =========================================
    // main sequence
    initial begin
        repeat (20) @(posedge mclk_i);
        rstn_i <= 1'b1;
        servo_on_i <= 1'b1;
        for (i = 0; i < 9; i++) begin
            rd(i[3:0], v);
            chk("reset_val", v, 16'h0000);
        end
        rd(4'hF, v);
        chk("unmapped", v, 16'h0000);
        for (i = 0; i < 6; i++) begin
            wr(i[3:0], 16'h0100 + i[15:0]);
            rd(i[3:0], v);
            chk("reg_rw", v, 16'h0100 + i[15:0]);
        end
        wr(ssd_pkg::REG_STATE, 16'h0003);
        rd(ssd_pkg::REG_STATE, v);
        chk("state_ro", v, 16'h0000);
        // slow stop off: prohibit must not start a ramp
        hit(5'h10, "off_alarm", 1'b0);
        chk("off_ramp", slow_active_o, 1'b0);
        hit(5'h00, "off_clear", 1'b0);
        wr(ssd_pkg::REG_MAINS_SEQ, 16'h0004);
        wr(ssd_pkg::REG_ALARM_SEQ, 16'h0004);
        wr(ssd_pkg::REG_FUNC_EXT, 16'h8400);
        cfg(16'h0000, 16'h0000, 16'h03E8);
        for (i = 0; i < 4; i++) begin
            run_stop(5'h10 >> i, 16'h0064, k);
        end
        lag = 1'b1;
        run_stop(5'h10, 16'h00C8, k);
        chk("lag_done", k >= 180 && k <= 200, 1'b1);
        lag = 1'b0;
        // linear then s-shaped ramp from 100 r/min
        wr(ssd_pkg::REG_IRQ_CLR, 16'h000F);
        cfg(16'h03E8, 16'h0000, 16'h03E8);
        run_stop(5'h10, 16'h0064, t_lin);
        chk("lin_time", t_lin >= 88 * TK && t_lin <= 92 * TK, 1'b1);
        rd(ssd_pkg::REG_IRQ_STAT, v);
        chk("irq_stat", v, 16'h0003);
        chk("irq_masked", irq_o, 1'b0);
        wr(ssd_pkg::REG_IRQ_EN, 16'h0002);
        repeat (2) @(negedge mclk_i);
        chk("irq_on", irq_o, 1'b1);
        wr(ssd_pkg::REG_IRQ_CLR, 16'h0002);
        rd(ssd_pkg::REG_IRQ_STAT, v);
        chk("irq_clr", v, 16'h0001);
        chk("irq_off", irq_o, 1'b0);
        cfg(16'h03E8, 16'h0014, 16'h03E8);
        run_stop(5'h10, 16'h0064, t_s);
        chk("s_extra", t_s - t_lin >= 6 * TK && t_s - t_lin <= 14 * TK, 1'b1);
        // alarm stop cut short by a 5 ms limit
        cfg(16'h03E8, 16'h0000, 16'h0005);
        wr(ssd_pkg::REG_IRQ_CLR, 16'h000F);
        arm(5'h02, 16'h00C8);
        for (k = 0; k < 10 * TK && alarm_o !== 1'b1; k++) @(negedge mclk_i);
        chk("tmo_time", k >= 4 * TK && k <= 7 * TK, 1'b1);
        rd(ssd_pkg::REG_IRQ_STAT, v);
        chk("tmo_stat", v, 16'h000D);
        hit(5'h00, "alarm_rel", 1'b0);
        // limit ignored for prohibit, non-stop alarm aborts at once
        arm(5'h10, 16'h00C8);
        repeat (10 * TK) @(negedge mclk_i);
        chk("nolimit", alarm_o, 1'b0);
        chk("still_ramp", slow_active_o, 1'b1);
        hit(5'h11, "nes_alarm", 1'b1);
        hit(5'h00, "nes_rel", 1'b0);
        // servo drop ends the ramp
        arm(5'h08, 16'h00C8);
        @(posedge mclk_i);
        servo_on_i <= 1'b0;
        repeat (2) @(negedge mclk_i);
        chk("servo_drop", force_pos_o, 1'b0);
        hit(5'h10, "servo_off_alarm", 1'b0);
        chk("servo_off_ramp", slow_active_o, 1'b0);
        hit(5'h00, "servo_rel", 1'b0);
        servo_on_i <= 1'b1;
        wr(ssd_pkg::REG_TLIMIT, 16'h0000);
        hit(5'h02, "zero_limit", 1'b1);
        chk("zero_ramp", slow_active_o, 1'b0);
        hit(5'h00, "zero_rel", 1'b0);
        complete_run();
    end
endmodule
